// [design/i2cbm_top.sv]
// i2c byte master port with four byte registers on classic wishbone
// assumes open-drain pins resolved outside; oe high pulls the wire low
// Functional notes
// - data-out write starts a bus transfer
// - data-out write clears transmitter empty flag
// - byte sent sets empty flag, may interrupt
// - first transfer: start, then address byte
// - data-out byte follows the address byte
// - address bits 7..1, direction bit 0, zero reset
// - direction zero means write to target
// - stop-after-write clear: no stop, bus held
// - stop-after-read clear: no stop after receive
// - held bus: next byte continues, no start
// - no response sets error, write one clears
// - bit 4 selects bus speed, 400 khz
// - received byte loaded sets receiver full
// - reading data-in clears receiver full
// - stop-after-write set: stop after sent byte
// - stop-after-read set: stop after received byte
// - direction one means read from target
`timescale 1ns/1ps
module i2cbm_top
  import i2cbm_pkg::*;
(
  input  wire logic        i_mclk,     // system clock
  input  wire logic        i_srst,     // sync reset, active high
  input  wire logic        i_wb_cyc,   // wishbone cycle
  input  wire logic        i_wb_stb,   // wishbone strobe
  input  wire logic        i_wb_we,    // wishbone write enable
  input  wire logic [31:0] i_wb_adr,   // wishbone byte address
  input  wire logic [3:0]  i_wb_sel,   // wishbone byte selects
  input  wire logic [31:0] i_wb_dat,   // wishbone write data
  output logic      [31:0] o_wb_dat,   // wishbone read data
  output logic             o_wb_ack,   // wishbone acknowledge
  output logic             o_irq,      // interrupt request, high
  input  wire logic        i_scl,      // scl wire level
  output logic             o_scl,      // scl drive value, always low
  output logic             o_scl_oe,   // scl pulled low when high
  input  wire logic        i_sda,      // sda wire level
  output logic             o_sda,      // sda drive value, always low
  output logic             o_sda_oe    // sda pulled low when high
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  i2cbm_state_e st_reg,    st_next;    // transfer sequencer
  logic [9:0]   qcnt_reg,  qcnt_next;  // quarter period counter
  logic [1:0]   ph_reg,    ph_next;    // quarter within a slot
  logic [3:0]   bit_reg,   bit_next;   // slot within a byte
  logic [7:0]   sh_reg,    sh_next;    // transmit shifter
  logic [7:0]   rsh_reg,   rsh_next;   // receive shifter
  logic         isadr_reg, isadr_next; // address byte on the wire
  logic         rdb_reg,   rdb_next;   // current byte is received
  logic         nack_reg,  nack_next;  // sampled acknowledge slot
  logic         go_reg,    go_next;    // launch pending
  logic [7:0]   cs_reg,    cs_next;    // control/status
  logic [7:0]   adr_reg,   adr_next;   // target address
  logic [7:0]   dout_reg,  dout_next;  // data out
  logic [7:0]   din_reg,   din_next;   // data in
  logic         ack_reg,   ack_next;   // bus acknowledge
  logic [31:0]  rdat_reg,  rdat_next;  // bus read data
  logic         irq_reg,   irq_next;   // interrupt line
  logic         scl_reg,   scl_next;   // scl pull-down
  logic         sda_reg,   sda_next;   // sda pull-down
  logic         low_reg;               // constant low drive value
  logic         sda_s1_reg, sda_s2_reg; // sda synchroniser
  logic         scl_s1_reg, scl_s2_reg; // scl synchroniser
  logic         tick, adv, byte_done;  // timing strobes
  logic         acc, take;             // bus request, bus commit

  function automatic logic hit(input logic [31:0] a,
                               input logic [15:0] idx);
    hit = (a == {14'h0000, idx, 2'b00});
  endfunction : hit

  // -----------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------
  // bus side first, sequencer second, so hardware sets win clears
  always_comb begin
    st_next = st_reg;     qcnt_next = qcnt_reg;  ph_next = ph_reg;
    bit_next = bit_reg;   sh_next = sh_reg;      rsh_next = rsh_reg;
    isadr_next = isadr_reg;  rdb_next = rdb_reg; nack_next = nack_reg;
    go_next = go_reg;     cs_next = cs_reg;      adr_next = adr_reg;
    dout_next = dout_reg; din_next = din_reg;
    scl_next = scl_reg;   sda_next = sda_reg;
    // quarter timing, speed picked per reload
    tick = (qcnt_reg == 10'h000);
    if (tick || st_reg == ST_IDLE || st_reg == ST_HOLD) begin
      qcnt_next = cs_reg[B_FAST_MODE] ? QTR_FAST : QTR_STD;
    end else begin
      qcnt_next = qcnt_reg - 10'h001;
    end
    // sampling waits until released scl reads high; a target
    // stretching scl holds the slot here instead of losing a bit
    adv = tick && !(st_reg == ST_BIT && ph_reg == 2'd2 && !scl_s2_reg);
    byte_done = (st_reg == ST_BIT) && (bit_reg == ACK_SLOT) &&
                (ph_reg == 2'd3) && adv;
    // single wait state slave: ack one cycle after the request
    acc = i_wb_cyc && i_wb_stb;
    ack_next = acc && !ack_reg;
    take = acc && ack_reg;
    rdat_next = 32'h0000_0000;
    if (ack_next && !i_wb_we) begin
      if (hit(i_wb_adr, IDX_CONTROL_STATUS)) begin
        rdat_next = {24'h000000, cs_reg};
      end else if (hit(i_wb_adr, IDX_RX_DATA_IN)) begin
        rdat_next = {24'h000000, din_reg};
      end else if (hit(i_wb_adr, IDX_TARGET_ADDRESS)) begin
        rdat_next = {24'h000000, adr_reg};
      end
    end
    // write effects at the edge that sees ack high
    if (take && i_wb_we && i_wb_sel[0]) begin
      if (hit(i_wb_adr, IDX_CONTROL_STATUS)) begin
        cs_next[B_STOP_AFTER_WRITE] = i_wb_dat[B_STOP_AFTER_WRITE];
        cs_next[B_STOP_AFTER_READ]  = i_wb_dat[B_STOP_AFTER_READ];
        cs_next[B_TX_IRQ_EN]        = i_wb_dat[B_TX_IRQ_EN];
        cs_next[B_FAST_MODE]        = i_wb_dat[B_FAST_MODE];
        cs_next[B_RX_IRQ_EN]        = i_wb_dat[B_RX_IRQ_EN];
        if (i_wb_dat[B_BUS_ERROR]) begin
          cs_next[B_BUS_ERROR] = 1'b0;
        end
      end else if (hit(i_wb_adr, IDX_TX_DATA_OUT)) begin
        dout_next = i_wb_dat[7:0];
        cs_next[B_TX_EMPTY] = 1'b0;
        go_next = 1'b1;
      end else if (hit(i_wb_adr, IDX_TARGET_ADDRESS)) begin
        adr_next = i_wb_dat[7:0];
      end
    end
    if (take && !i_wb_we && hit(i_wb_adr, IDX_RX_DATA_IN)) begin
      cs_next[B_RX_FULL] = 1'b0;
    end
    // sequencer
    case (st_reg)
      ST_IDLE: begin
        if (go_reg) begin
          go_next = 1'b0;
          st_next = ST_START;
          ph_next = 2'd0;
          sh_next = adr_reg;
          isadr_next = 1'b1;
          rdb_next = 1'b0;
        end
      end
      ST_START: begin
        if (adv) begin
          ph_next = ph_reg + 2'd1;
          if (ph_reg == 2'd0) begin
            sda_next = 1'b1;        // sda falls while scl is high
          end else begin
            scl_next = 1'b1;
            st_next = ST_BIT;
            ph_next = 2'd0;
            bit_next = 4'h0;
          end
        end
      end
      ST_BIT: begin
        if (adv) begin
          ph_next = ph_reg + 2'd1;
          case (ph_reg)
            2'd0: begin
              if (bit_reg != ACK_SLOT) begin
                sda_next = !rdb_reg && !sh_reg[7];
              end else begin
                // receiver acks unless this byte ends the read
                sda_next = rdb_reg && !cs_reg[B_STOP_AFTER_READ];
              end
            end
            2'd1: begin
              scl_next = 1'b0;
            end
            2'd2: begin
              if (bit_reg != ACK_SLOT) begin
                rsh_next = {rsh_reg[6:0], sda_s2_reg};
              end else begin
                nack_next = sda_s2_reg;
              end
            end
            default: begin
              scl_next = 1'b1;
              if (bit_reg != ACK_SLOT) begin
                bit_next = bit_reg + 4'h1;
                sh_next = {sh_reg[6:0], 1'b0};
              end else if (isadr_reg && nack_reg) begin
                cs_next[B_BUS_ERROR] = 1'b1;
                cs_next[B_TX_EMPTY] = 1'b1;
                st_next = ST_STOP;
              end else if (isadr_reg) begin
                isadr_next = 1'b0;
                bit_next = 4'h0;
                if (adr_reg[B_DIRECTION]) begin
                  rdb_next = 1'b1;
                  cs_next[B_TX_EMPTY] = 1'b1;  // dummy byte consumed
                end else begin
                  sh_next = dout_reg;
                end
              end else if (rdb_reg) begin
                din_next = rsh_reg;
                cs_next[B_RX_FULL] = 1'b1;
                cs_next[B_TX_EMPTY] = 1'b1;
                if (cs_reg[B_STOP_AFTER_READ]) begin
                  st_next = ST_STOP;
                end else begin
                  st_next = ST_HOLD;
                end
              end else begin
                cs_next[B_TX_EMPTY] = 1'b1;
                if (nack_reg) begin
                  cs_next[B_BUS_ERROR] = 1'b1;
                  st_next = ST_STOP;
                end else if (cs_reg[B_STOP_AFTER_WRITE]) begin
                  st_next = ST_STOP;
                end else begin
                  st_next = ST_HOLD;
                end
              end
            end
          endcase
        end
      end
      ST_HOLD: begin
        // scl stays low; the next launch skips start and address
        if (go_reg) begin
          go_next = 1'b0;
          st_next = ST_BIT;
          ph_next = 2'd0;
          bit_next = 4'h0;
          rdb_next = adr_reg[B_DIRECTION];
          sh_next = dout_reg;
        end
      end
      default: begin
        // stop: sda low, scl up, then sda up while scl high
        if (adv) begin
          ph_next = ph_reg + 2'd1;
          case (ph_reg)
            2'd0:    sda_next = 1'b1;
            2'd1:    scl_next = 1'b0;
            2'd2:    sda_next = 1'b0;
            default: st_next = ST_IDLE;
          endcase
        end
      end
    endcase
    irq_next = (cs_next[B_TX_EMPTY] && cs_next[B_TX_IRQ_EN]) ||
               (cs_next[B_RX_FULL] && cs_next[B_RX_IRQ_EN]);
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_reg <= ST_IDLE;       qcnt_reg <= QTR_STD;   ph_reg <= 2'd0;
      bit_reg <= 4'h0;         sh_reg <= 8'h00;       rsh_reg <= 8'h00;
      isadr_reg <= 1'b0;       rdb_reg <= 1'b0;       nack_reg <= 1'b0;
      go_reg <= 1'b0;
      cs_reg <= RST_CONTROL_STATUS;
      adr_reg <= RST_TARGET_ADDRESS;
      dout_reg <= RST_TX_DATA_OUT;
      din_reg <= RST_RX_DATA_IN;
      ack_reg <= 1'b0;         rdat_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;         scl_reg <= 1'b0;       sda_reg <= 1'b0;
      low_reg <= 1'b0;
      sda_s1_reg <= 1'b1;      sda_s2_reg <= 1'b1;
      scl_s1_reg <= 1'b1;      scl_s2_reg <= 1'b1;
    end else begin
      st_reg <= st_next;       qcnt_reg <= qcnt_next; ph_reg <= ph_next;
      bit_reg <= bit_next;     sh_reg <= sh_next;     rsh_reg <= rsh_next;
      isadr_reg <= isadr_next; rdb_reg <= rdb_next;   nack_reg <= nack_next;
      go_reg <= go_next;       cs_reg <= cs_next;     adr_reg <= adr_next;
      dout_reg <= dout_next;   din_reg <= din_next;
      ack_reg <= ack_next;     rdat_reg <= rdat_next;
      irq_reg <= irq_next;     scl_reg <= scl_next;   sda_reg <= sda_next;
      low_reg <= 1'b0;
      sda_s1_reg <= i_sda;     sda_s2_reg <= sda_s1_reg;
      scl_s1_reg <= i_scl;     scl_s2_reg <= scl_s1_reg;
    end
  end

  assign o_wb_dat = rdat_reg;
  assign o_wb_ack = ack_reg;
  assign o_irq    = irq_reg;
  assign o_scl    = low_reg;
  assign o_sda    = low_reg;
  assign o_scl_oe = scl_reg;
  assign o_sda_oe = sda_reg;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  logic wr_dout;
  assign wr_dout = take && i_wb_we && i_wb_sel[0] &&
                   hit(i_wb_adr, IDX_TX_DATA_OUT);

  chk_launch_start: assert property (
    wr_dout && st_reg == ST_IDLE |-> ##[1:1000] st_reg == ST_START)
    else $error("data-out write did not launch a start");
  chk_empty_clear: assert property (
    wr_dout && !byte_done |=> !cs_reg[B_TX_EMPTY])
    else $error("tx empty not cleared by data-out write");
  chk_start_cond: assert property (
    st_reg == ST_START && ph_reg == 2'd0 && adv
    |=> o_sda_oe && !o_scl_oe)
    else $error("start did not pull sda low with scl high");
  chk_addr_first: assert property (
    $rose(st_reg == ST_START) |-> sh_reg == adr_reg && isadr_reg)
    else $error("address byte not loaded first");
  chk_stop_write: assert property (
    byte_done && !isadr_reg && !rdb_reg && !nack_reg &&
    cs_reg[B_STOP_AFTER_WRITE] |=> st_reg == ST_STOP ##1
    cs_reg[B_TX_EMPTY])
    else $error("no stop after sent byte");
  chk_hold_write: assert property (
    byte_done && !isadr_reg && !rdb_reg && !nack_reg &&
    !cs_reg[B_STOP_AFTER_WRITE] |=> st_reg == ST_HOLD && o_scl_oe)
    else $error("bus not held after sent byte");
  chk_rx_load: assert property (
    byte_done && rdb_reg && !isadr_reg
    |=> cs_reg[B_RX_FULL] && din_reg == $past(rsh_reg))
    else $error("received byte not loaded");
  chk_rx_clear: assert property (
    take && !i_wb_we && hit(i_wb_adr, IDX_RX_DATA_IN) && !byte_done
    |=> !cs_reg[B_RX_FULL])
    else $error("reading data-in left receiver full");
  chk_err_set: assert property (
    byte_done && nack_reg && !rdb_reg |=> cs_reg[B_BUS_ERROR] &&
    st_reg == ST_STOP)
    else $error("missing response did not set error");
  chk_irq_gate: assert property (
    ##1 o_irq == ((cs_reg[B_TX_EMPTY] && cs_reg[B_TX_IRQ_EN]) ||
                  (cs_reg[B_RX_FULL] && cs_reg[B_RX_IRQ_EN])))
    else $error("interrupt does not follow enabled flags");
  chk_reset_vals: assert property (
    $past(i_srst) |-> cs_reg == RST_CONTROL_STATUS &&
    adr_reg == RST_TARGET_ADDRESS && !o_wb_ack && !o_irq &&
    !o_scl_oe && !o_sda_oe)
    else $error("control/status reset value wrong");
  cov_write_hold: cover property (st_reg == ST_HOLD && !rdb_reg);
  cov_read_byte:  cover property (byte_done && rdb_reg);
  cov_nack_err:   cover property ($rose(cs_reg[B_BUS_ERROR]));
endmodule : i2cbm_top

// [include/i2cbm_pkg.sv]
// constants and types for the byte-oriented i2c master port
// assumes a 250 mhz system clock and a classic wishbone register bus
package i2cbm_pkg;
  // -----------------------------------------------------------------
  // register indices, byte address is four times the index
  // -----------------------------------------------------------------
  localparam logic [15:0] IDX_CONTROL_STATUS = 16'hFFF0; // control/status
  localparam logic [15:0] IDX_TX_DATA_OUT    = 16'hFFF1; // write launches
  localparam logic [15:0] IDX_RX_DATA_IN     = 16'hFFF2; // received byte
  localparam logic [15:0] IDX_TARGET_ADDRESS = 16'hFFF3; // address + dir

  // -----------------------------------------------------------------
  // control/status field positions
  // -----------------------------------------------------------------
  localparam int B_STOP_AFTER_WRITE = 0; // stop after sent byte
  localparam int B_STOP_AFTER_READ  = 1; // stop after received byte
  localparam int B_TX_IRQ_EN        = 2; // tx empty interrupt enable
  localparam int B_TX_EMPTY         = 3; // transmitter empty flag
  localparam int B_FAST_MODE        = 4; // 1 selects 400 khz
  localparam int B_BUS_ERROR        = 5; // target did not respond
  localparam int B_RX_IRQ_EN        = 6; // rx full interrupt enable
  localparam int B_RX_FULL          = 7; // receiver full flag
  localparam int B_DIRECTION        = 0; // in target_address, 1 = read

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL_STATUS = 8'h08; // only tx empty set
  localparam logic [7:0] RST_TARGET_ADDRESS = 8'h00;
  localparam logic [7:0] RST_TX_DATA_OUT    = 8'h00;
  localparam logic [7:0] RST_RX_DATA_IN     = 8'h00;

  // -----------------------------------------------------------------
  // timing: one bit slot is four quarter periods
  // -----------------------------------------------------------------
  localparam int CLK_KHZ      = 250000; // system clock rate
  localparam int SCL_STD_KHZ  = 100;    // standard bus speed
  localparam int SCL_FAST_KHZ = 400;    // fast bus speed
  localparam logic [9:0] QTR_STD  =
    10'((CLK_KHZ + 4 * SCL_STD_KHZ - 1) / (4 * SCL_STD_KHZ) - 1);
  localparam logic [9:0] QTR_FAST =
    10'((CLK_KHZ + 4 * SCL_FAST_KHZ - 1) / (4 * SCL_FAST_KHZ) - 1);
  localparam logic [3:0] ACK_SLOT = 4'h8; // ninth slot of a byte

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BIT, ST_HOLD, ST_STOP
  } i2cbm_state_e;
endpackage : i2cbm_pkg

// [dv/i2cbm_eeprom_model.sv]
// behavioural i2c target memory facing the byte master port
// assumes wire levels resolved by the bench, pull-ups on both lines
`timescale 1ns/1ps
module i2cbm_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50, // address this target answers
  parameter logic [7:0] RD_FIRST = 8'hA5  // first byte returned on reads
) (
  input  wire logic i_scl,    // scl wire level
  input  wire logic i_sda,    // sda wire level
  output logic      o_sda_oe  // high pulls sda low
);
  // -----------------------------------------------------------------
  // frame tracking, counters are peeked by the bench
  // -----------------------------------------------------------------
  int         bitc, starts, stops;      // slot count, frame markers
  logic [7:0] sh, tx, addr_byte;        // shifter, read byte, address
  logic       first, sel, rd, mack, act; // phase and direction flags
  logic [7:0] got_q[$];                 // bytes written to us
  initial begin
    o_sda_oe = 1'h0;
    {starts, stops, bitc} = '0;
    {act, first, sel, rd} = '0;
    tx = RD_FIRST;
  end
  // start and stop only count while scl is high
  always @(negedge i_sda) if (i_scl === 1'h1) begin
    starts++;
    {act, first, bitc, o_sda_oe} = {1'h1, 1'h1, 32'h0, 1'h0};
  end
  always @(posedge i_sda) if (i_scl === 1'h1 && act) begin
    stops++;
    {act, sel} = '0;
  end
  // bits shift in msb first, ninth slot samples the master ack
  always @(posedge i_scl) if (act) begin
    if (bitc < 8) sh = {sh[6:0], i_sda};
    else mack = ~i_sda;
    bitc++;
  end
  // data changes only while scl is low, so no false frame markers
  always @(negedge i_scl) if (act) begin
    if (bitc == 9) begin
      // a master nack ends our reply; released line reads as pull-up
      if (sel && rd && (first || mack)) begin
        if (!first) tx++;
        o_sda_oe = ~tx[7];
      end else o_sda_oe = 1'h0;
      {first, bitc} = '0;
    end else if (bitc == 8) begin
      if (first) begin
        addr_byte = sh;
        sel = (sh[7:1] == DEV_ADDR);                 // unknown: no ack
        rd = sh[0];
        o_sda_oe = sel;
      end else if (rd) o_sda_oe = 1'h0;
      else begin
        if (sel) got_q.push_back(sh);
        o_sda_oe = sel;
      end
    end else if (sel && rd && !first) o_sda_oe = ~tx[3'(7 - bitc)];
  end
endmodule : i2cbm_eeprom_model

// [dv/test_i2cbm_top.sv]
// self-checking bench for the i2c byte master port
// assumes the target model in dv; fast bus speed for short runs except in the standard-speed error test
`timescale 1ns/1ps
module test_i2cbm_top;
  import i2cbm_pkg::*;
  // -----------------------------------------------------------------
  // stimulus, wires and instances
  // -----------------------------------------------------------------
  localparam logic [6:0] DEV = 7'h50;  // model address
  localparam logic [7:0] RDB = 8'hA5;  // model first read byte
  localparam int         HOLD = 4 * (QTR_FAST + 1) + 8; // one stop span
  logic        i_mclk, i_srst, cyc, stb, we, o_wb_ack, o_irq;
  logic [31:0] adr, wdat, o_wb_dat;
  logic [3:0]  sel;
  logic        scl_oe, sda_oe, m_oe;   // pull-down enables
  logic        scl_do, sda_do;         // drive values, must be low
  logic [7:0]  rv;                     // last read byte
  int          err_count, checks;
  wire logic   scl_w, sda_w;           // resolved open-drain lines
  // pull-ups unless driven; a high drive value would break transfers
  assign scl_w = scl_oe ? scl_do : 1'h1;
  assign sda_w = (sda_oe ? sda_do : 1'h1) & ~m_oe;
  i2cbm_top dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .o_irq(o_irq), .i_scl(scl_w), .o_scl(scl_do), .o_scl_oe(scl_oe),
    .i_sda(sda_w), .o_sda(sda_do), .o_sda_oe(sda_oe));
  i2cbm_eeprom_model #(.DEV_ADDR(DEV), .RD_FIRST(RDB)) eep (
    .i_scl(scl_w), .i_sda(sda_w), .o_sda_oe(m_oe));
  initial begin
    i_mclk = 1'h0;
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // one classic cycle; ack is sampled at the edge, then released
  task automatic wb(input logic w, input logic [15:0] idx,
                    input logic [7:0] d);
    int n;
    @(posedge i_mclk);
    {cyc, stb, we} <= {1'h1, 1'h1, w};
    adr <= {14'h0, idx, 2'h0};
    wdat <= {24'h0, d};
    n = 0;
    do begin @(posedge i_mclk); n++; end
    while (o_wb_ack !== 1'h1 && n < 50);
    if (o_wb_ack !== 1'h1) begin err_count++; give_verdict(); end
    rv = o_wb_dat[7:0];
    {cyc, stb, we} <= 3'h0;
  endtask : wb
  // polls control_status until a bit takes the wanted value
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    do begin wb(1'h0, IDX_CONTROL_STATUS, 8'h00); n++; end
    while (rv[b] !== v && n < 8000);
    chk("status bit", {7'h0, v}, {7'h0, rv[b]});
    if (rv[b] !== v) give_verdict();
  endtask : wait_stat
  task automatic wait_stops(input int n);
    int k;
    k = 0;
    while (eep.stops != n && k < 3000) begin @(posedge i_mclk); k++; end
    chk("stops", 8'(n), 8'(eep.stops));
  endtask : wait_stops
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_regs();
    wb(1'h0, IDX_CONTROL_STATUS, 8'h00); chk("status rst", 8'h08, rv);
    wb(1'h0, IDX_TARGET_ADDRESS, 8'h00); chk("addr rst", 8'h00, rv);
    wb(1'h0, IDX_RX_DATA_IN, 8'h00); chk("din rst", 8'h00, rv);
    wb(1'h1, IDX_TARGET_ADDRESS, 8'hA5);
    wb(1'h0, IDX_TARGET_ADDRESS, 8'h00); chk("addr rw", 8'hA5, rv);
    wb(1'h1, IDX_CONTROL_STATUS, 8'hFF);
    wb(1'h0, IDX_CONTROL_STATUS, 8'h00); chk("status rw", 8'h5F, rv);
    chk("irq on", 8'h01, {7'h0, o_irq});
    wb(1'h1, IDX_CONTROL_STATUS, 8'h10);
    wb(1'h0, IDX_CONTROL_STATUS, 8'h00); chk("irq off", 8'h00, {7'h0, o_irq});
    wb(1'h1, 16'h0010, 8'h55);
    wb(1'h0, 16'h0010, 8'h00); chk("unmapped", 8'h00, rv);
    wb(1'h0, IDX_TX_DATA_OUT, 8'h00); chk("dout wo", 8'h00, rv);
    $display("test registers done");
  endtask : t_regs
  task automatic t_write();
    wb(1'h1, IDX_CONTROL_STATUS, 8'h14);
    wb(1'h1, IDX_TARGET_ADDRESS, {DEV, 1'h0});
    wb(1'h1, IDX_TX_DATA_OUT, 8'h01);
    wb(1'h0, IDX_CONTROL_STATUS, 8'h00); chk("txe busy", 8'h00, {7'h0, rv[3]});
    chk("irq busy", 8'h00, {7'h0, o_irq});
    wait_stat(3, 1'h1); chk("irq txe", 8'h01, {7'h0, o_irq});
    repeat (HOLD) @(posedge i_mclk);
    chk("starts", 8'h01, 8'(eep.starts));
    chk("held", 8'h00, 8'(eep.stops));
    wb(1'h1, IDX_TX_DATA_OUT, 8'h02);
    wait_stat(3, 1'h1); chk("no restart", 8'h01, 8'(eep.starts));
    wb(1'h1, IDX_CONTROL_STATUS, 8'h15);
    wb(1'h1, IDX_TX_DATA_OUT, 8'h03);
    wait_stat(3, 1'h1); wait_stops(1);
    chk("addr byte", {DEV, 1'h0}, eep.addr_byte);
    chk("byte count", 8'h03, 8'(eep.got_q.size()));
    for (int i = 0; i < eep.got_q.size(); i++)
      chk("byte", 8'(i + 1), eep.got_q[i]);
    $display("test write done");
  endtask : t_write
  task automatic t_read();
    wb(1'h1, IDX_CONTROL_STATUS, 8'h50);
    wb(1'h1, IDX_TARGET_ADDRESS, {DEV, 1'h1});
    wb(1'h1, IDX_TX_DATA_OUT, 8'h00);
    wait_stat(7, 1'h1); chk("irq rxf", 8'h01, {7'h0, o_irq});
    wb(1'h0, IDX_RX_DATA_IN, 8'h00); chk("rx byte", RDB, rv);
    wb(1'h0, IDX_CONTROL_STATUS, 8'h00); chk("rxf clr", 8'h00, {7'h0, rv[7]});
    repeat (HOLD) @(posedge i_mclk);
    chk("rd held", 8'h01, 8'(eep.stops));
    wb(1'h1, IDX_CONTROL_STATUS, 8'h52);
    wb(1'h1, IDX_TX_DATA_OUT, 8'h00);
    wait_stat(7, 1'h1);
    wb(1'h0, IDX_RX_DATA_IN, 8'h00); chk("rx next", RDB + 8'h01, rv);
    wait_stops(2);
    chk("rd starts", 8'h02, 8'(eep.starts));
    $display("test read done");
  endtask : t_read
  task automatic t_error();
    // standard speed: a fast bus would have stopped shortly before this
    wb(1'h1, IDX_CONTROL_STATUS, 8'h01);
    wb(1'h1, IDX_TARGET_ADDRESS, {7'h21, 1'h0});
    wb(1'h1, IDX_TX_DATA_OUT, 8'h5A);
    repeat (11 * HOLD) @(posedge i_mclk);
    chk("slow bus", 8'h02, 8'(eep.stops));
    wait_stat(5, 1'h1); wait_stops(3);
    chk("no data", 8'h03, 8'(eep.got_q.size()));
    wb(1'h1, IDX_CONTROL_STATUS, 8'h11);
    wb(1'h0, IDX_CONTROL_STATUS, 8'h00); chk("err w0", 8'h01, {7'h0, rv[5]});
    wb(1'h1, IDX_CONTROL_STATUS, 8'h31);
    wb(1'h0, IDX_CONTROL_STATUS, 8'h00); chk("err w1", 8'h00, {7'h0, rv[5]});
    $display("test error done");
  endtask : t_error
  initial begin
    {i_srst, cyc, stb, we, adr, wdat} = {1'h1, 67'h0};
    sel = 4'hF;
    {err_count, checks} = '0;
    repeat (2) @(posedge i_mclk);
    i_srst <= 1'h0;
    t_regs();
    t_write();
    t_read();
    t_error();
    give_verdict();
  end
endmodule : test_i2cbm_top
